// File: dipc_params.svh
// constants for the dual issue pairing check
`ifndef DIPC_PARAMS_SVH
`define DIPC_PARAMS_SVH
`define DIPC_REG_IDX_W 4
`define DIPC_PC_IDX 4'hf
`define DIPC_FP_IDX_W 5
`define DIPC_CYC_W 6
`define DIPC_HAS_FPU_DEF 1'b1
`define DIPC_SHIFT_MAX 2'h3
`endif

// File: dipc_pkg.sv
// types shared by the dual issue pairing check
package dipc_pkg;
  typedef enum logic [4:0] {
    DIPC_CL_OTHER = 5'h00,
    DIPC_CL_BRANCH_IMM = 5'h01,
    DIPC_CL_IT = 5'h02,
    DIPC_CL_NOP = 5'h03,
    DIPC_CL_LDST_MULTI = 5'h04,
    DIPC_CL_MUL_SHORT = 5'h05,
    DIPC_CL_MUL_MULTI = 5'h06,
    DIPC_CL_COPROC = 5'h07,
    DIPC_CL_PROC_CTRL = 5'h08,
    DIPC_CL_LOAD = 5'h09,
    DIPC_CL_STORE = 5'h0a,
    DIPC_CL_MOV_REG = 5'h0b,
    DIPC_CL_MOV_IMM = 5'h0c,
    DIPC_CL_MOV_WIDE = 5'h0d,
    DIPC_CL_DATA_PROC = 5'h0e,
    DIPC_CL_BITFIELD = 5'h0f,
    DIPC_CL_EXTEND = 5'h10,
    DIPC_CL_SIMD_ADDSUB = 5'h11,
    DIPC_CL_REVERSE = 5'h12,
    DIPC_CL_FP_SP_OP = 5'h13,
    DIPC_CL_FP_DP_OP = 5'h14,
    DIPC_CL_FP_XFER32 = 5'h15,
    DIPC_CL_FP_LDST_MULTI = 5'h16,
    DIPC_CL_FP_LOAD_SP = 5'h17,
    DIPC_CL_FP_LOAD_DP = 5'h18,
    DIPC_CL_FP_STORE_SP = 5'h19,
    DIPC_CL_FP_STATUS_XFER = 5'h1a,
    DIPC_CL_FP_STATUS_TO_FLAGS = 5'h1b
  } dipc_class_e;

  typedef enum logic [3:0] {
    DIPC_SP_ARITH = 4'h0,
    DIPC_SP_MAC = 4'h1,
    DIPC_SP_MOV_IMM = 4'h2,
    DIPC_SP_MOV_REG = 4'h3,
    DIPC_SP_NEG = 4'h4,
    DIPC_SP_ABS = 4'h5,
    DIPC_SP_CVT_DBL = 4'h6,
    DIPC_SP_DIV = 4'h7,
    DIPC_SP_SQRT = 4'h8,
    DIPC_SP_CMP = 4'h9,
    DIPC_SP_CVT = 4'ha
  } dipc_spop_e;

  typedef enum logic [1:0] {
    DIPC_ST_IDLE = 2'b00,
    DIPC_ST_SINGLE = 2'b01,
    DIPC_ST_DUAL = 2'b10,
    DIPC_ST_STALL = 2'b11
  } dipc_state_e;

  // one decoded instruction as it stands at the issue stage
  typedef struct packed {
    logic valid;
    logic compressed;
    dipc_class_e iclass;
    dipc_spop_e spop;
    logic sets_flags;
    logic reg_shift;
    logic imm_shifted;
    logic [1:0] ld_shift;
    logic ld_reg_offset;
    logic [2:0] src_used;
    logic [2:0][3:0] src_reg;
    logic [1:0] dst_used;
    logic [1:0][3:0] dst_reg;
    logic fp_dst_used;
    logic [4:0] fp_dst;
    logic [5:0] cycles;
  } dipc_insn_s;

  typedef struct packed {
    logic issue_first;
    logic issue_second;
    logic dual;
    logic stall;
    logic [5:0] cycles;
  } dipc_issue_s;
endpackage

// File: dipc_class_match.sv
// younger class sets used by the permitted pairing cases
`timescale 1ns/1ps
`default_nettype none
module dipc_class_match
  import dipc_pkg::*;
(
  input wire dipc_insn_s younger,
  output logic y_branch_like,
  output logic y_int_load_set,
  output logic y_int_c_set,
  output logic y_xfer32,
  output logic y_sp_restricted,
  output logic y_sp_not_mac
);
  always_comb begin
    y_branch_like = younger.iclass inside {DIPC_CL_BRANCH_IMM, DIPC_CL_IT,
                                           DIPC_CL_NOP};
    y_int_c_set = younger.iclass inside {DIPC_CL_DATA_PROC, DIPC_CL_MOV_REG,
                    DIPC_CL_MOV_IMM, DIPC_CL_MOV_WIDE, DIPC_CL_BITFIELD,
                    DIPC_CL_EXTEND, DIPC_CL_SIMD_ADDSUB, DIPC_CL_REVERSE};
    // load set also bars data processing with register-specified shift
    y_int_load_set = y_int_c_set && !younger.reg_shift;
    y_xfer32 = younger.iclass == DIPC_CL_FP_XFER32;
    y_sp_restricted = younger.iclass == DIPC_CL_FP_SP_OP &&
      !(younger.spop inside {DIPC_SP_MOV_IMM, DIPC_SP_NEG, DIPC_SP_ABS,
                             DIPC_SP_CVT_DBL, DIPC_SP_DIV, DIPC_SP_SQRT});
    y_sp_not_mac = younger.iclass == DIPC_CL_FP_SP_OP &&
                   younger.spop != DIPC_SP_MAC;
  end
endmodule // dipc_class_match
`default_nettype wire

// File: dipc_pair_check.sv
// dual issue pairing decision at the issue stage
// Notes on behaviour
// RULE_01: pair costs only the larger cycle count
// RULE_02: legal pairs always dual issue unless disabled
// RULE_03: interlock on either stalls both of pair
// RULE_04: pair only when both present same cycle
// RULE_05: younger reads pc only if immediate branch
// RULE_06: older writing pc refuses pairing
// RULE_07: both from same instruction set encoding
// RULE_08: younger sources must not hit older destinations
// RULE_09: only listed class combinations may pair
// RULE_10: case a: broad older, branch/it/nop younger
// RULE_11: case b1: simple load then integer op
// RULE_12: case b2: simple store, same as b1
// RULE_13: case c: plain moves then integer ops
// RULE_14: floating cases only with floating unit present
// RULE_15: case a-f: floating older, branch/it/nop younger
// RULE_16: floating variants add transfers and sp ops
// RULE_17: case f1: sp op then c set
// RULE_18: sp load like b1-f; dp load b1
// RULE_19: sp store: b1, non-mac sp, transfers
// RULE_20: case f3: transfers/sp moves like sp store
// RULE_21: case f4: non-flag older then restricted sp
// RULE_22: older is first, evaluated combinationally each cycle
`timescale 1ns/1ps
`default_nettype none
`include "dipc_params.svh"
module dipc_pair_check
  import dipc_pkg::*;
#(
  parameter bit HAS_FPU = `DIPC_HAS_FPU_DEF
)(
  input wire logic clock,
  input wire logic sys_rst,
  input wire dipc_insn_s older,
  input wire dipc_insn_s younger,
  input wire logic dual_issue_disable,
  input wire logic older_interlock,
  input wire logic younger_interlock,
  output dipc_issue_s issue_reg,
  output dipc_state_e state_reg
);
  logic y_branch_like;
  logic y_int_load_set;
  logic y_int_c_set;
  logic y_xfer32;
  logic y_sp_restricted;
  logic y_sp_not_mac;
  logic general_ok;
  logic case_ok;
  logic fp_case_ok;
  logic pair_ok;
  logic dep_hit;
  logic pc_src;
  logic pc_dst;
  logic older_simple_ld;
  logic older_simple_st;
  logic older_plain_mov;
  logic older_fp;
  logic older_case_a;
  logic older_case_f4;
  logic mac_dst_clash;
  logic b1f_set;
  logic f2st_set;
  dipc_issue_s issue_next;
  dipc_state_e state_next;

  function automatic logic reg_hit(input logic [2:0] used,
                                   input logic [2:0][3:0] regs,
                                   input logic [3:0] idx);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      hit = hit | (used[i] && regs[i] == idx);
    end
    return hit;
  endfunction

  function automatic logic [5:0] max_cycles(input logic [5:0] a,
                                            input logic [5:0] b);
    return (a > b) ? a : b;
  endfunction

  dipc_class_match u_match (
    .younger(younger),
    .y_branch_like(y_branch_like),
    .y_int_load_set(y_int_load_set),
    .y_int_c_set(y_int_c_set),
    .y_xfer32(y_xfer32),
    .y_sp_restricted(y_sp_restricted),
    .y_sp_not_mac(y_sp_not_mac)
  );

  always_comb begin
    pc_src = reg_hit(younger.src_used, younger.src_reg, `DIPC_PC_IDX);
    pc_dst = reg_hit({1'b0, older.dst_used}, {4'h0, older.dst_reg},
                     `DIPC_PC_IDX);
    dep_hit = 1'b0;
    for (int d = 0; d < 2; d++) begin
      dep_hit = dep_hit | (older.dst_used[d] &&
        reg_hit(younger.src_used, younger.src_reg, older.dst_reg[d])); // RULE_08
    end
    general_ok = older.valid && younger.valid // RULE_04
      && !(pc_src && younger.iclass != DIPC_CL_BRANCH_IMM) // RULE_05
      && !pc_dst // RULE_06
      && older.compressed == younger.compressed; // RULE_07
    general_ok = general_ok && !dep_hit; // RULE_08
  end

  always_comb begin
    older_fp = older.iclass inside {DIPC_CL_FP_SP_OP, DIPC_CL_FP_DP_OP,
      DIPC_CL_FP_XFER32, DIPC_CL_FP_LDST_MULTI, DIPC_CL_FP_LOAD_SP,
      DIPC_CL_FP_LOAD_DP, DIPC_CL_FP_STORE_SP, DIPC_CL_FP_STATUS_XFER,
      DIPC_CL_FP_STATUS_TO_FLAGS};
    older_case_a = !(older.iclass inside {DIPC_CL_LDST_MULTI,
      DIPC_CL_COPROC, DIPC_CL_PROC_CTRL}) && !older_fp
      && !(older.iclass inside {DIPC_CL_MUL_SHORT, DIPC_CL_MUL_MULTI}
           && older.sets_flags); // RULE_10
    older_simple_ld = older.iclass == DIPC_CL_LOAD &&
      older.ld_shift <= `DIPC_SHIFT_MAX &&
      (older.ld_reg_offset || older.ld_shift == 2'h0); // RULE_11
    older_simple_st = older.iclass == DIPC_CL_STORE &&
      !older.ld_reg_offset; // RULE_12
    older_plain_mov = !older.sets_flags && (older.iclass inside
      {DIPC_CL_MOV_REG, DIPC_CL_MOV_WIDE} ||
      (older.iclass == DIPC_CL_MOV_IMM && !older.imm_shifted)); // RULE_13
    older_case_f4 = !older.sets_flags && !(older.iclass inside
      {DIPC_CL_LDST_MULTI, DIPC_CL_COPROC, DIPC_CL_MUL_MULTI,
       DIPC_CL_FP_DP_OP, DIPC_CL_PROC_CTRL, DIPC_CL_FP_LDST_MULTI,
       DIPC_CL_FP_STATUS_XFER, DIPC_CL_FP_STATUS_TO_FLAGS,
       DIPC_CL_FP_LOAD_DP}) && // RULE_18
      !(older.iclass == DIPC_CL_FP_SP_OP &&
        older.spop == DIPC_SP_CVT_DBL); // RULE_21
    mac_dst_clash = older.iclass == DIPC_CL_FP_SP_OP &&
      older.spop == DIPC_SP_MAC && y_xfer32 &&
      younger.fp_dst_used && older.fp_dst == younger.fp_dst; // RULE_17
    b1f_set = y_int_load_set || y_sp_restricted || y_xfer32; // RULE_16
    f2st_set = y_int_load_set || y_sp_not_mac || y_xfer32; // RULE_19
  end

  // integer cases always exist; floating ones gated by the unit
  always_comb begin
    case_ok = (older_case_a && y_branch_like) // RULE_10
      || (older_simple_ld && y_int_load_set) // RULE_11
      || (older_simple_st && y_int_load_set) // RULE_12
      || (older_plain_mov && y_int_c_set); // RULE_13
    fp_case_ok = 1'b0;
    unique case (older.iclass)
      DIPC_CL_FP_SP_OP: begin
        fp_case_ok = (y_branch_like && older.spop != DIPC_SP_CVT_DBL) // RULE_15
          || (!(older.spop inside {DIPC_SP_MOV_IMM, DIPC_SP_CVT_DBL,
                DIPC_SP_ABS, DIPC_SP_NEG}) &&
              (y_int_c_set || y_xfer32) && !mac_dst_clash) // RULE_17
          || (older.spop inside {DIPC_SP_MOV_REG, DIPC_SP_ABS,
                DIPC_SP_NEG} && f2st_set); // RULE_20
      end
      DIPC_CL_FP_XFER32: fp_case_ok = y_branch_like || f2st_set; // RULE_20
      DIPC_CL_FP_LOAD_SP: fp_case_ok = y_branch_like || b1f_set; // RULE_18
      DIPC_CL_FP_LOAD_DP: fp_case_ok = y_branch_like || y_int_load_set; // RULE_18
      DIPC_CL_FP_STORE_SP: fp_case_ok = y_branch_like || f2st_set; // RULE_19
      DIPC_CL_FP_STATUS_TO_FLAGS: fp_case_ok = y_branch_like;
      default: fp_case_ok = 1'b0;
    endcase
    fp_case_ok = fp_case_ok
      || (older_simple_ld && b1f_set) // RULE_16
      || (older_simple_st && b1f_set) // RULE_16
      || (older_plain_mov && y_xfer32) // RULE_16
      || (older_case_f4 && (y_sp_restricted || y_xfer32)); // RULE_21
    // the clash bars the pair whichever case would let it through
    fp_case_ok = fp_case_ok && HAS_FPU && !mac_dst_clash; // RULE_14 RULE_17
    pair_ok = general_ok && (case_ok || fp_case_ok); // RULE_09 RULE_22
  end

  always_comb begin
    issue_next = '0;
    state_next = DIPC_ST_IDLE;
    if (older.valid) begin
      issue_next.dual = pair_ok && !dual_issue_disable; // RULE_02
      issue_next.stall = older_interlock ||
        (issue_next.dual && younger_interlock); // RULE_03
      issue_next.issue_first = !issue_next.stall;
      issue_next.issue_second = issue_next.dual && !issue_next.stall;
      // the shorter of the pair is charged nothing
      issue_next.cycles = issue_next.dual ?
        max_cycles(older.cycles, younger.cycles) : older.cycles; // RULE_01
      if (issue_next.stall) begin
        state_next = DIPC_ST_STALL;
      end else if (issue_next.dual) begin
        state_next = DIPC_ST_DUAL;
      end else begin
        state_next = DIPC_ST_SINGLE;
      end
    end
  end

  // registered so every output leaves straight from a flop
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      issue_reg <= '0;
    end else begin
      issue_reg <= issue_next;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= DIPC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule // dipc_pair_check
`default_nettype wire

// File: dipc_pair_check_asserts.sv
// port assertions for the dual issue pairing check
`timescale 1ns/1ps
`default_nettype none
module dipc_pair_check_asserts
  import dipc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire dipc_insn_s older,
  input wire dipc_insn_s younger,
  input wire logic dual_issue_disable,
  input wire logic older_interlock,
  input wire logic younger_interlock,
  input wire dipc_issue_s issue_reg,
  input wire dipc_state_e state_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_DISABLE: assert property (
    dual_issue_disable |=> !issue_reg.dual) else $error("dual while off");
  AST_ABSENT: assert property (
    !older.valid |=> issue_reg == '0 && state_reg == DIPC_ST_IDLE)
    else $error("issue with no older");
  AST_NO_YOUNG: assert property (
    !younger.valid |=> !issue_reg.issue_second) else $error("ghost pair");
  AST_PC_DST: assert property (
    older.dst_used[0] && older.dst_reg[0] == 4'hf |=> !issue_reg.dual)
    else $error("pair after pc write");
  AST_MIXED: assert property (
    older.compressed != younger.compressed |=> !issue_reg.dual)
    else $error("mixed encodings paired");
  AST_DEP: assert property (
    older.dst_used[0] && younger.src_used[0] &&
    younger.src_reg[0] == older.dst_reg[0] |=> !issue_reg.dual)
    else $error("dependent pair");
  AST_CYC_DUAL: assert property (
    issue_reg.dual |-> issue_reg.cycles ==
    ($past(older.cycles) > $past(younger.cycles) ?
     $past(older.cycles) : $past(younger.cycles)))
    else $error("pair cycle count");
  AST_CYC_ONE: assert property (
    issue_reg.issue_first && !issue_reg.dual |->
    issue_reg.cycles == $past(older.cycles)) else $error("single cycles");
  AST_STALL: assert property (
    older_interlock |=> !issue_reg.issue_first && !issue_reg.issue_second)
    else $error("issue under interlock");
  AST_PAIR_ST: assert property (
    issue_reg.dual |-> (issue_reg.stall ?
      (!issue_reg.issue_first && !issue_reg.issue_second &&
       state_reg == DIPC_ST_STALL) :
      (issue_reg.issue_first && issue_reg.issue_second &&
       state_reg == DIPC_ST_DUAL))) else $error("pair state");
endmodule // dipc_pair_check_asserts
`default_nettype wire

// File: dipc_pair_check_tb_top.sv
// testbench of the dual issue pairing check
`timescale 1ns/1ps
`default_nettype none
module dipc_pair_check_tb_top
  import dipc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  dipc_insn_s older = '0;
  dipc_insn_s younger = '0;
  logic dual_issue_disable = 1'b0;
  logic older_interlock = 1'b0;
  logic younger_interlock = 1'b0;
  dipc_issue_s issue_reg;
  dipc_state_e state_reg;
  int n_mismatch = 0;
  int checked = 0;
  int n_cyc = 0;
  dipc_pair_check #(.HAS_FPU(1'b1)) u_dipc_pair_check (
    .clock(clock), .sys_rst(sys_rst), .older(older), .younger(younger),
    .dual_issue_disable(dual_issue_disable),
    .older_interlock(older_interlock), .younger_interlock(younger_interlock),
    .issue_reg(issue_reg), .state_reg(state_reg));
  initial begin
    forever #12.5 clock = ~clock;
  end
  task automatic give_verdict();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ceiling well above the 84 or so cycles the scenarios need
  always @(posedge clock) begin
    n_cyc++;
    if (n_cyc == 2000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  function automatic dipc_insn_s mk(dipc_class_e c);
    dipc_insn_s i;
    i = '0;
    i.valid = 1'b1;
    i.iclass = c;
    i.src_used = 3'h1;
    i.src_reg[0] = 4'h2;
    i.dst_used = 2'h1;
    i.dst_reg[0] = 4'h1;
    i.cycles = 6'h01;
    return i;
  endfunction
  // il is {older, younger} interlock; pr is the expected pairing
  task automatic run(dipc_insn_s o, dipc_insn_s y, logic dis,
                     logic [1:0] il, logic pr);
    dipc_issue_s e;
    dipc_state_e es;
    @(posedge clock);
    #1;
    older = o;
    younger = y;
    dual_issue_disable = dis;
    {older_interlock, younger_interlock} = il;
    @(posedge clock);
    #1;
    e = '0;
    es = DIPC_ST_IDLE;
    if (o.valid) begin
      e.dual = pr;
      e.stall = il[1] || (il[0] && pr);
      e.issue_first = !e.stall;
      e.issue_second = pr && !e.stall;
      e.cycles = (pr && y.cycles > o.cycles) ? y.cycles : o.cycles;
      if (e.stall) es = DIPC_ST_STALL;
      else if (pr) es = DIPC_ST_DUAL;
      else es = DIPC_ST_SINGLE;
    end
    checked++;
    if (issue_reg !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, issue_reg, e);
      n_mismatch++;
    end
    checked++;
    if (state_reg !== es) begin
      $display("[ERR] %0t state got %h exp %h", $time, state_reg, es);
      n_mismatch++;
    end
  endtask
  task automatic s_case_a();
    dipc_insn_s o;
    dipc_insn_s y;
    o = mk(DIPC_CL_DATA_PROC);
    o.cycles = 6'h03;
    y = mk(DIPC_CL_BRANCH_IMM);
    run(o, y, 1'b0, 2'b00, 1'b1);
    y.cycles = 6'h05;
    run(o, y, 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_MUL_SHORT), mk(DIPC_CL_IT), 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_LDST_MULTI), mk(DIPC_CL_NOP), 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_PROC_CTRL), mk(DIPC_CL_NOP), 1'b0, 2'b00, 1'b0);
    o = mk(DIPC_CL_MUL_SHORT);
    o.sets_flags = 1'b1;
    run(o, mk(DIPC_CL_BRANCH_IMM), 1'b0, 2'b00, 1'b0);
  endtask
  task automatic s_mem_mov();
    dipc_insn_s o;
    dipc_insn_s y;
    o = mk(DIPC_CL_LOAD);
    o.ld_reg_offset = 1'b1;
    o.ld_shift = 2'h3;
    run(o, mk(DIPC_CL_DATA_PROC), 1'b0, 2'b00, 1'b1);
    y = mk(DIPC_CL_DATA_PROC);
    y.reg_shift = 1'b1;
    run(mk(DIPC_CL_LOAD), y, 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_STORE), mk(DIPC_CL_EXTEND), 1'b0, 2'b00, 1'b1);
    o = mk(DIPC_CL_STORE);
    o.ld_reg_offset = 1'b1;
    run(o, mk(DIPC_CL_SIMD_ADDSUB), 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_LOAD), mk(DIPC_CL_LOAD), 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_MOV_WIDE), mk(DIPC_CL_REVERSE), 1'b0, 2'b00, 1'b1);
    o = mk(DIPC_CL_MOV_IMM);
    o.imm_shifted = 1'b1;
    run(o, mk(DIPC_CL_BITFIELD), 1'b0, 2'b00, 1'b0);
    o = mk(DIPC_CL_MOV_REG);
    o.sets_flags = 1'b1;
    run(o, mk(DIPC_CL_DATA_PROC), 1'b0, 2'b00, 1'b0);
  endtask
  task automatic s_conditions();
    dipc_insn_s o;
    dipc_insn_s y;
    o = mk(DIPC_CL_MOV_REG);
    y = mk(DIPC_CL_DATA_PROC);
    run(o, y, 1'b1, 2'b00, 1'b0);
    run(o, y, 1'b0, 2'b01, 1'b1);
    run(o, y, 1'b0, 2'b10, 1'b1);
    y.valid = 1'b0;
    run(o, y, 1'b0, 2'b00, 1'b0);
    run(y, mk(DIPC_CL_NOP), 1'b0, 2'b00, 1'b0);
    y = mk(DIPC_CL_DATA_PROC);
    y.src_reg[0] = 4'hf;
    run(o, y, 1'b0, 2'b00, 1'b0);
    y.iclass = DIPC_CL_BRANCH_IMM;
    run(o, y, 1'b0, 2'b00, 1'b1);
    y = mk(DIPC_CL_DATA_PROC);
    y.src_reg[0] = 4'h1;
    run(o, y, 1'b0, 2'b00, 1'b0);
    y.src_reg[0] = 4'h2;
    y.compressed = 1'b1;
    run(o, y, 1'b0, 2'b00, 1'b0);
    o.dst_reg[0] = 4'hf;
    run(o, mk(DIPC_CL_DATA_PROC), 1'b0, 2'b00, 1'b0);
  endtask
  task automatic s_float();
    dipc_insn_s o;
    dipc_insn_s y;
    run(mk(DIPC_CL_FP_SP_OP), mk(DIPC_CL_DATA_PROC), 1'b0, 2'b00, 1'b1);
    o = mk(DIPC_CL_FP_SP_OP);
    o.spop = DIPC_SP_CVT_DBL;
    run(o, mk(DIPC_CL_BRANCH_IMM), 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_FP_LDST_MULTI), mk(DIPC_CL_NOP), 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_FP_STORE_SP), mk(DIPC_CL_FP_XFER32), 1'b0, 2'b00, 1'b1);
    y = mk(DIPC_CL_FP_SP_OP);
    y.spop = DIPC_SP_MAC;
    run(mk(DIPC_CL_FP_STORE_SP), y, 1'b0, 2'b00, 1'b1);
    y.spop = DIPC_SP_DIV;
    run(mk(DIPC_CL_FP_STORE_SP), y, 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_FP_LOAD_DP), mk(DIPC_CL_EXTEND), 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_FP_LOAD_DP), mk(DIPC_CL_FP_XFER32), 1'b0, 2'b00, 1'b0);
    y.spop = DIPC_SP_DIV;
    run(mk(DIPC_CL_LOAD), y, 1'b0, 2'b00, 1'b0);
    run(mk(DIPC_CL_LOAD), mk(DIPC_CL_FP_XFER32), 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_FP_XFER32), mk(DIPC_CL_FP_SP_OP), 1'b0, 2'b00, 1'b1);
    run(mk(DIPC_CL_DATA_PROC), mk(DIPC_CL_FP_SP_OP), 1'b0, 2'b00, 1'b1);
    o = mk(DIPC_CL_FP_SP_OP);
    o.spop = DIPC_SP_NEG;
    run(o, y, 1'b0, 2'b00, 1'b1);
    o.spop = DIPC_SP_MAC;
    o.fp_dst = 5'h05;
    y = mk(DIPC_CL_FP_XFER32);
    y.fp_dst_used = 1'b1;
    y.fp_dst = 5'h05;
    run(o, y, 1'b0, 2'b00, 1'b0);
    y.fp_dst = 5'h06;
    run(o, y, 1'b0, 2'b00, 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    s_case_a();
    s_mem_mov();
    s_conditions();
    s_float();
    give_verdict();
  end
endmodule // dipc_pair_check_tb_top
bind dipc_pair_check dipc_pair_check_asserts u_dipc_pair_check_asserts (
  .clock(clock), .sys_rst(sys_rst), .older(older), .younger(younger),
  .dual_issue_disable(dual_issue_disable),
  .older_interlock(older_interlock), .younger_interlock(younger_interlock),
  .issue_reg(issue_reg), .state_reg(state_reg));
`default_nettype wire
